// ==== design/ssl_pkg.sv ====
package ssl_pkg;

    localparam int unsigned CHAIN_W   = 8;
    localparam int unsigned SYNC_W    = 2;
    localparam logic [CHAIN_W-1:0] CHAIN_CLEAR = 8'h00;
    localparam logic [SYNC_W-1:0]  SYNC_RESET  = 2'h0;

    typedef logic [CHAIN_W-1:0] ssl_byte_t;

    // Host-driven control pins, both raw and after each synchroniser stage.
    typedef struct packed {
        logic chain_in;
        logic shift_clock;
        logic latch_clock;
        logic shift_clear_n;
        logic output_enable_n;
    } ssl_pins_s;

endpackage

// ==== design/ssl_driver.sv ====
// What this block does
// - Eight-bit shift chain feeds eight-bit latch.
// - Shift clock rise shifts, captures chain input.
// - Latch clock rise copies chain into latch.
// - Clear high lets latch reach outputs.
// - Clear low forces chain, latch, serial output zero.
// - Enable high forces all drains off.
// - Enable low: outputs follow latch directly.
// - Bit one sinks current, zero off.
// - Serial output presents chain's leaving bit.
module ssl_driver
    import ssl_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            reset,
    input  wire logic            chain_in,
    input  wire logic            shift_clock,
    input  wire logic            latch_clock,
    input  wire logic            shift_clear_n,
    input  wire logic            output_enable_n,
    output logic      [CHAIN_W-1:0] drain_on,
    output logic      [CHAIN_W-1:0] drain_oe,
    output logic                 serial_out
);

    // Two-stage synchronisers; only the second stage is read by logic.
    ssl_pins_s pins_now;
    ssl_pins_s pins_meta_r;
    ssl_pins_s pins_sync_r;
    logic      shift_clock_prev_r;
    logic      latch_clock_prev_r;
    ssl_byte_t chain_r;
    ssl_byte_t latch_r;
    ssl_byte_t buffer_nxt;

    logic      shift_rise;
    logic      latch_rise;
    logic      regs_cleared;
    logic      buffers_blocked;

    // A rising edge is a high sample whose previous sample was low.
    function automatic logic rose_now(
        input logic level_now,
        input logic level_before
    );
        return level_now && !level_before;
    endfunction

    // Clear wins over every other cause of change in the registers.
    function automatic logic clear_now(
        input logic      sync_reset,
        input ssl_pins_s pins
    );
        return sync_reset || !pins.shift_clear_n;
    endfunction

    // The output buffers are forced low while cleared or disabled.
    function automatic logic blocked_now(
        input logic      sync_reset,
        input ssl_pins_s pins
    );
        return clear_now(sync_reset, pins) || pins.output_enable_n;
    endfunction

    // A latch pulse is passed straight on so the buffers do not lag the latch.
    function automatic ssl_byte_t buffer_source(
        input logic      take_chain,
        input ssl_byte_t chain,
        input ssl_byte_t latch
    );
        return take_chain ? chain : latch;
    endfunction

    always_comb begin
        pins_now                 = '0;
        pins_now.chain_in        = chain_in;
        pins_now.shift_clock     = shift_clock;
        pins_now.latch_clock     = latch_clock;
        pins_now.shift_clear_n   = shift_clear_n;
        pins_now.output_enable_n = output_enable_n;
    end

    // First stage: may go metastable, so nothing but the second stage reads it.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pins_meta_r <= '0;
        end else begin
            pins_meta_r <= pins_now;
        end
    end

    // Second stage: a reset value of zero holds the clear until pins are seen.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pins_sync_r <= '0;
        end else begin
            pins_sync_r <= pins_meta_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            shift_clock_prev_r <= 1'b0;
        end else begin
            shift_clock_prev_r <= pins_sync_r.shift_clock;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            latch_clock_prev_r <= 1'b0;
        end else begin
            latch_clock_prev_r <= pins_sync_r.latch_clock;
        end
    end

    assign shift_rise      = rose_now(pins_sync_r.shift_clock, shift_clock_prev_r);
    assign latch_rise      = rose_now(pins_sync_r.latch_clock, latch_clock_prev_r);
    assign regs_cleared    = clear_now(reset, pins_sync_r);
    assign buffers_blocked = blocked_now(reset, pins_sync_r);

    // Shift chain: bit 0 is the first stage.
    always_ff @(posedge core_clk) begin
        if (regs_cleared) begin
            chain_r <= CHAIN_CLEAR;
        end else if (shift_rise) begin
            chain_r <= {chain_r[CHAIN_W-2:0], pins_sync_r.chain_in};
        end
    end

    // Storage latch; clear reaches the chain, latch, serial and buffer registers, not the synchronisers.
    always_ff @(posedge core_clk) begin
        if (regs_cleared) begin
            latch_r <= CHAIN_CLEAR;
        end else if (latch_rise) begin
            latch_r <= chain_r;
        end
    end

    // Serial output tracks the last stage, so it moves with each shift.
    always_ff @(posedge core_clk) begin
        if (regs_cleared) begin
            serial_out <= 1'b0;
        end else if (shift_rise) begin
            serial_out <= chain_r[CHAIN_W-2];
        end
    end

    // Clear and disable both hold every buffer bit low.
    assign buffer_nxt = buffers_blocked
                      ? CHAIN_CLEAR
                      : buffer_source(latch_rise, chain_r, latch_r);

    // Output buffers: a one turns the open-drain switch on (pin pulled low).
    always_ff @(posedge core_clk) begin
        drain_on <= buffer_nxt;
    end

    // The open-drain pin is driven exactly while its switch is on.
    always_ff @(posedge core_clk) begin
        drain_oe <= buffer_nxt;
    end

endmodule

// ==== bench/ssl_driver_assertions.sv ====
module ssl_driver_chk
    import ssl_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               reset,
    input wire logic               chain_in,
    input wire logic               shift_clock,
    input wire logic               latch_clock,
    input wire logic               shift_clear_n,
    input wire logic               output_enable_n,
    input wire logic               serial_out,
    input wire logic [CHAIN_W-1:0] drain_on,
    input wire logic [CHAIN_W-1:0] drain_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_eq; drain_oe == drain_on; endproperty
    a_eq: assert property (p_eq) else $error("bad enable");
    property p_dis; output_enable_n[*4] |-> !drain_on; endproperty
    a_dis: assert property (p_dis) else $error("on while off");
    property p_doe; output_enable_n[*4] |-> !drain_oe; endproperty
    a_doe: assert property (p_doe) else $error("driven while off");
    property p_clr; (!shift_clear_n)[*4] |-> !drain_on && !serial_out; endproperty
    a_clr: assert property (p_clr) else $error("not cleared");
    property p_clo; (!shift_clear_n)[*4] |-> !drain_oe; endproperty
    a_clo: assert property (p_clo) else $error("driven in clear");
    property p_rst; $fell(reset) |-> !drain_on && !serial_out; endproperty
    a_rst: assert property (p_rst) else $error("not idle");
    property p_ser; $changed(serial_out) |-> $past(shift_clock, 3) || !$past(shift_clear_n, 3);
    endproperty
    a_ser: assert property (p_ser) else $error("stray serial");
    property p_drn; $changed(drain_on) |-> $past(latch_clock, 3) || !$past(shift_clear_n, 3)
        || $past(output_enable_n, 3) != $past(output_enable_n, 4); endproperty
    a_drn: assert property (p_drn) else $error("stray drain");
    c_ser: cover property ($rose(serial_out));
    c_dim: cover property ($fell(output_enable_n));
    c_clr: cover property ($fell(shift_clear_n));
endmodule
bind ssl_driver ssl_driver_chk u_chk (.core_clk, .reset, .chain_in, .shift_clock, .latch_clock,
    .shift_clear_n, .output_enable_n, .serial_out, .drain_on, .drain_oe);

// ==== bench/ssl_host.sv ====
module ssl_host (
    input  wire logic core_clk,
    output logic      chain_in,
    output logic      shift_clock,
    output logic      latch_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {chain_in, shift_clock, latch_clock} = 3'h0;
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 18; i++) begin
            chain_in <= i < 16 ? b[7 - i / 2] : 1'b0;
            shift_clock <= i < 16 && i[0];
            latch_clock <= i == 16;
            repeat (4) @(posedge core_clk);
        end
    endtask
endmodule

// ==== bench/test_ssl_driver.sv ====
module test_ssl_driver import ssl_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, reset = 1'b1, shift_clear_n = 1'b0, output_enable_n = 1'b0;
    logic chain_in, shift_clock, latch_clock, serial_out;
    ssl_byte_t drain_on, drain_oe;
    int failures = 0, total_checks = 0;
    always #2 core_clk = ~core_clk;
    ssl_host u_host (.core_clk, .chain_in, .shift_clock, .latch_clock);
    ssl_driver u_ssl_driver (.core_clk, .reset, .chain_in, .shift_clock, .latch_clock,
        .shift_clear_n, .output_enable_n, .drain_on, .drain_oe, .serial_out);
    task automatic chk(input string n, input ssl_byte_t s, e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic pins(input logic c, g);
        shift_clear_n <= c;
        output_enable_n <= g;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic load(input ssl_byte_t b);
        u_host.send(b);
        chk("drain_on", drain_on, b);
        chk("drain_oe", drain_oe, b);
        chk("serial_out", {7'h00, serial_out}, {7'h00, b[7]});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        pins(1'b1, 1'b0);
        load(8'hA5);
        load(8'h3C);
        pins(1'b1, 1'b1);
        chk("disabled", drain_on, 8'h00);
        pins(1'b1, 1'b0);
        chk("enabled", drain_on, 8'h3C);
        pins(1'b0, 1'b0);
        chk("cleared", drain_on, 8'h00);
        pins(1'b1, 1'b0);
        chk("released", {7'h00, serial_out}, 8'h00);
        wrap_up();
    end
endmodule
